// ===== verilog/ata_tf_cfg.svh
// Constants for the task-file command controller: offsets, bits, codes.
// Assumes a 32-bit APB bus with byte addresses and a 20 MHz core clock.
`ifndef ATA_TF_CFG_SVH
`define ATA_TF_CFG_SVH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFF_DATA    8'h00
`define OFF_ERRFEAT 8'h04
`define OFF_COUNT   8'h08
`define OFF_SECTOR  8'h0c
`define OFF_CYL_LO  8'h10
`define OFF_CYL_HI  8'h14
`define OFF_DRVHEAD 8'h18
`define OFF_STATCMD 8'h1c
`define OFF_ALTCTRL 8'h20
`define OFF_DRVADDR 8'h24
`define OFF_CARDCFG 8'h28
// ****************************************************************
// Field positions
// ****************************************************************
`define ST_BSY  7
`define ST_DRDY 6
`define ST_DSC  4
`define ST_DRQ  3
`define ST_ERR  0
`define DC_TASK_FILE_RESET_REQUEST 2
`define DC_IRQ_DISABLE 1
`define DH_DRV  4
`define ER_ABRT 2
// ****************************************************************
// Reset values and results
// ****************************************************************
`define DEF_COUNT   8'h01
`define DEF_SECTOR  8'h01
`define DEF_DRVHEAD 8'ha0
`define DEF_CFG     8'h00
`define DIAG_PASS   8'h01
`define PWR_ACTIVE  8'hff
`define PWR_STANDBY 8'h00
`define WEAR_NONE   8'h00
// ****************************************************************
// Command codes
// ****************************************************************
`define CMD_RD     8'h20, 8'h21, 8'h22, 8'h23, 8'hc4
`define CMD_VERIFY 8'h40, 8'h41
`define CMD_WR     8'h30, 8'h31, 8'h32, 8'h33, 8'h38, 8'h3c, 8'hc5, 8'hcd
`define CMD_RDBUF  8'he4
`define CMD_WRBUF  8'he8
`define CMD_IDENT  8'hec
`define CMD_FORMAT 8'h50
`define CMD_ERASE  8'hc0
`define CMD_DIAG   8'h90
`define CMD_CHKPWR 8'he5, 8'h98
`define CMD_IDLE   8'he3, 8'h97
`define CMD_IDLEI  8'he1, 8'h95
`define CMD_STBY   8'he2, 8'h96, 8'he0, 8'h94
`define CMD_SLEEP  8'he6, 8'h99
`define CMD_WEAR   8'hf5
`define CMD_NOP    8'h1?, 8'h7?, 8'h03, 8'h91, 8'hef, 8'hc6, 8'h87
// ****************************************************************
// Timing
// ****************************************************************
`define CLK_NS  50
`define EXEC_NS 1000
`endif

// ===== verilog/ata_tf_pkg.sv
// Types shared by the task-file command controller.
// Assumes the constants header is compiled alongside.
package ata_tf_pkg;
    typedef enum logic [2:0] {S_IDLE, S_EXEC, S_XIN, S_XOUT, S_TASK_FILE_RESET_REQUEST}
        state_e;
    typedef enum logic [3:0] {OP_BAD, OP_RD, OP_VERIFY, OP_WR, OP_RDBUF,
        OP_WRBUF, OP_IDENT, OP_FORMAT, OP_ERASE, OP_DIAG, OP_CHKPWR,
        OP_IDLE, OP_IDLEI, OP_STBY, OP_SLEEP, OP_WEAR} op_e;
    typedef struct packed {
        logic        start;
        op_e         op;
        logic        rd;
        logic        wr;
        logic [15:0] wdata;
    } media_s;
    typedef struct packed {
        state_e      st;
        op_e         op;
        logic [7:0]  feat;
        logic [7:0]  count;
        logic [7:0]  sector;
        logic [15:0] cyl;
        logic [7:0]  head;
        logic [7:0]  err_reg;
        logic [7:0]  cfg;
        logic        busy;
        logic        drdy;
        logic        dsc;
        logic        drq;
        logic        errb;
        logic        irq_disable;
        logic        task_file_reset_request;
        logic        irq_pend;
        logic        apd_en;
        logic        standby;
        logic [7:0]  timer;
        logic [9:0]  words;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq_n;
        media_s      media;
    } state_s;
endpackage

// ===== verilog/ata_task_file_command_control.sv
// Task-file registers, command decoder, soft reset and interrupt gate.
// Assumes an APB master on core_clk and a media engine that presents
// the next read data word on media_rdata and moves on after each media.rd.
//
// Behaviour
// - While soft reset bit is one, command registers are held reset.
// - Soft reset leaves card configuration register unchanged.
// - Device stays in reset until host writes the bit back to zero.
// - Interrupt disable bit one suppresses the active-low interrupt.
// - Drive address bits 5..2 return inverted head select bits.
// - Drive address register is read only; writes are ignored.
// - Read, write and read multiple codes dispatch to media operations.
// - Paired power management codes are treated as equivalent.
// - Check power mode reports current power mode.
// - Diagnostic command runs self test and reports result.
// - Erase command pre-erases the addressed sectors.
// - Format track accepts one sector of host data.
// - Format track data is not written to the media.
// - Identify returns the parameter block through data register.
// - Every command checks the drive select bit first.
// - Command write clears status bits 0,4,6, sets busy.
// - Head number field is drive/head bits 3..0.
// - Idle with nonzero count enables auto power down.
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "ata_tf_cfg.svh"
module ata_task_file_command_control #(
    parameter int SECTOR_WORDS = 256
) (
    input  wire logic                core_clk,
    input  wire logic                reset,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                drive_is_one,
    input  wire logic [15:0]         media_rdata,
    output ata_tf_pkg::media_s       media,
    output logic                     interrupt_request_n
);
    localparam int EXEC_CYC = (`EXEC_NS + `CLK_NS - 1) / `CLK_NS;

    ata_tf_pkg::state_s s, n;
    logic               acc;
    logic               done;
    logic               wr;
    logic               rd;
    logic               cmd_ok;
    logic [7:0]         status;
    logic [31:0]        rdv;
    logic               rd_err;
    logic               last;

    // ****************************************************************
    // Command decode
    // ****************************************************************
    function automatic ata_tf_pkg::op_e decode(input logic [7:0] c);
        ata_tf_pkg::op_e o;
        o = ata_tf_pkg::OP_BAD;
        casez (c)
            `CMD_RD:     o = ata_tf_pkg::OP_RD;
            `CMD_VERIFY: o = ata_tf_pkg::OP_VERIFY;
            `CMD_WR:     o = ata_tf_pkg::OP_WR;
            `CMD_RDBUF:  o = ata_tf_pkg::OP_RDBUF;
            `CMD_WRBUF:  o = ata_tf_pkg::OP_WRBUF;
            `CMD_IDENT:  o = ata_tf_pkg::OP_IDENT;
            `CMD_FORMAT: o = ata_tf_pkg::OP_FORMAT;
            `CMD_ERASE:  o = ata_tf_pkg::OP_ERASE;
            `CMD_DIAG:   o = ata_tf_pkg::OP_DIAG;
            `CMD_CHKPWR: o = ata_tf_pkg::OP_CHKPWR;
            `CMD_IDLE:   o = ata_tf_pkg::OP_IDLE;
            `CMD_IDLEI:  o = ata_tf_pkg::OP_IDLEI;
            `CMD_STBY:   o = ata_tf_pkg::OP_STBY;
            `CMD_SLEEP:  o = ata_tf_pkg::OP_SLEEP;
            `CMD_WEAR:   o = ata_tf_pkg::OP_WEAR;
            `CMD_NOP:    o = ata_tf_pkg::OP_VERIFY;
            default:     o = ata_tf_pkg::OP_BAD;
        endcase
        return o;
    endfunction

    // ****************************************************************
    // Bus decode and read mux
    // ****************************************************************
    assign acc  = psel && penable;
    assign done = acc && s.pready;
    assign wr   = done && pwrite;
    assign rd   = done && !pwrite;
    assign last = (s.words == 10'(SECTOR_WORDS - 1));
    // The drive select bit decides whether this card is addressed.
    assign cmd_ok = wr && paddr == `OFF_STATCMD && !s.busy && !s.task_file_reset_request
        && (s.head[`DH_DRV] == drive_is_one);
    assign status = {s.busy, s.drdy, 1'b0, s.dsc, s.drq, 2'b00, s.errb};

    always_comb
    begin
        rdv    = 32'h0;
        rd_err = 1'b0;
        case (paddr)
            `OFF_DATA:    rdv = {16'h0, media_rdata};
            `OFF_ERRFEAT: rdv = {24'h0, s.err_reg};
            `OFF_COUNT:   rdv = {24'h0, s.count};
            `OFF_SECTOR:  rdv = {24'h0, s.sector};
            `OFF_CYL_LO:  rdv = {24'h0, s.cyl[7:0]};
            `OFF_CYL_HI:  rdv = {24'h0, s.cyl[15:8]};
            `OFF_DRVHEAD: rdv = {24'h0, s.head};
            `OFF_STATCMD: rdv = {24'h0, status};
            `OFF_ALTCTRL: rdv = {24'h0, status};
            `OFF_DRVADDR: rdv = {26'h0, ~s.head[3:0], 2'b00};
            `OFF_CARDCFG: rdv = {24'h0, s.cfg};
            default:      rd_err = 1'b1;
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        n = s;
        n.media.start = 1'b0;
        n.media.rd    = 1'b0;
        n.media.wr    = 1'b0;
        n.pready  = acc && !s.pready;
        n.prdata  = (acc && !s.pready && !pwrite) ? rdv : s.prdata;
        n.pslverr = acc && !s.pready && rd_err;
        if (s.timer != 8'h0)
            n.timer = s.timer - 8'h1;

        // Task-file parameters are only taken while busy is clear and soft reset is not held.
        if (wr && !s.busy && !s.task_file_reset_request)
        begin
            case (paddr)
                `OFF_ERRFEAT: n.feat = pwdata[7:0];
                `OFF_COUNT:   n.count = pwdata[7:0];
                `OFF_SECTOR:  n.sector = pwdata[7:0];
                `OFF_CYL_LO:  n.cyl[7:0] = pwdata[7:0];
                `OFF_CYL_HI:  n.cyl[15:8] = pwdata[7:0];
                `OFF_DRVHEAD: n.head = pwdata[7:0];
                `OFF_CARDCFG: n.cfg = pwdata[7:0];
                default:      n.feat = s.feat;
            endcase
        end

        // Status read acknowledges the interrupt; alternate does not.
        if (rd && paddr == `OFF_STATCMD)
            n.irq_pend = 1'b0;

        case (s.st)
            ata_tf_pkg::S_EXEC:
            begin
                if (s.timer == 8'h0)
                begin
                    n.busy  = 1'b0;
                    n.drdy  = 1'b1;
                    n.dsc   = 1'b1;
                    n.words = 10'h0;
                    n.st    = ata_tf_pkg::S_IDLE;
                    n.irq_pend = 1'b1;
                    if (s.op != ata_tf_pkg::OP_BAD)
                    begin
                        n.media.start = 1'b1;
                        n.media.op    = s.op;
                    end
                    case (s.op)
                        ata_tf_pkg::OP_RD, ata_tf_pkg::OP_RDBUF,
                        ata_tf_pkg::OP_IDENT:
                        begin
                            n.drq = 1'b1;
                            n.st  = ata_tf_pkg::S_XOUT;
                        end
                        ata_tf_pkg::OP_WR, ata_tf_pkg::OP_WRBUF,
                        ata_tf_pkg::OP_FORMAT:
                        begin
                            n.drq = 1'b1;
                            n.irq_pend = s.irq_pend
                                && !(rd && paddr == `OFF_STATCMD);
                            n.st  = ata_tf_pkg::S_XIN;
                        end
                        ata_tf_pkg::OP_DIAG:
                            n.err_reg = `DIAG_PASS;
                        ata_tf_pkg::OP_CHKPWR:
                            n.count = s.standby ? `PWR_STANDBY
                                                : `PWR_ACTIVE;
                        ata_tf_pkg::OP_IDLE:
                        begin
                            n.apd_en  = (s.count != 8'h0);
                            n.standby = 1'b0;
                        end
                        ata_tf_pkg::OP_IDLEI:
                            n.standby = 1'b0;
                        ata_tf_pkg::OP_STBY, ata_tf_pkg::OP_SLEEP:
                            n.standby = 1'b1;
                        ata_tf_pkg::OP_WEAR:
                            n.count = `WEAR_NONE;
                        ata_tf_pkg::OP_BAD:
                        begin
                            n.errb    = 1'b1;
                            n.err_reg = 8'h1 << `ER_ABRT;
                        end
                        default:
                            n.err_reg = 8'h0;
                    endcase
                end
            end
            ata_tf_pkg::S_XOUT:
            begin
                if (rd && paddr == `OFF_DATA)
                begin
                    n.media.rd = 1'b1;
                    n.words    = s.words + 10'h1;
                    if (last)
                    begin
                        n.drq = 1'b0;
                        n.st  = ata_tf_pkg::S_IDLE;
                    end
                end
            end
            ata_tf_pkg::S_XIN:
            begin
                if (wr && paddr == `OFF_DATA)
                begin
                    // Format data is swallowed so stored sectors survive.
                    n.media.wr    = (s.op != ata_tf_pkg::OP_FORMAT);
                    n.media.wdata = pwdata[15:0];
                    n.words       = s.words + 10'h1;
                    if (last)
                    begin
                        n.drq      = 1'b0;
                        n.irq_pend = 1'b1;
                        n.st       = ata_tf_pkg::S_IDLE;
                    end
                end
            end
            ata_tf_pkg::S_TASK_FILE_RESET_REQUEST:
            begin
                if (!s.task_file_reset_request && s.timer == 8'h0)
                begin
                    n.busy = 1'b0;
                    n.drdy = 1'b1;
                    n.dsc  = 1'b1;
                    n.st   = ata_tf_pkg::S_IDLE;
                end
            end
            default:
                n.st = s.st;
        endcase

        if (cmd_ok)
        begin
            n.busy  = 1'b1;
            n.errb  = 1'b0;
            n.dsc   = 1'b0;
            n.drdy  = 1'b0;
            n.drq   = 1'b0;
            n.op    = decode(pwdata[7:0]);
            n.timer = 8'(EXEC_CYC);
            n.st    = ata_tf_pkg::S_EXEC;
        end

        // Control bits 7..4, 3 and 0 carry nothing for the card.
        if (wr && paddr == `OFF_ALTCTRL)
        begin
            n.irq_disable = pwdata[`DC_IRQ_DISABLE];
            n.task_file_reset_request = pwdata[`DC_TASK_FILE_RESET_REQUEST];
            if (!pwdata[`DC_TASK_FILE_RESET_REQUEST] && s.task_file_reset_request)
                n.timer = 8'(EXEC_CYC);
        end

        // Held in reset for as long as the bit stays set; the card
        // configuration register is deliberately not touched here.
        if (n.task_file_reset_request || (wr && paddr == `OFF_ALTCTRL && s.task_file_reset_request))
        begin
            n.st      = ata_tf_pkg::S_TASK_FILE_RESET_REQUEST;
            n.busy    = 1'b1;
            n.drq     = 1'b0;
            n.errb    = 1'b0;
            n.drdy    = 1'b0;
            n.irq_pend = 1'b0;
            n.feat    = 8'h0;
            n.count   = `DEF_COUNT;
            n.sector  = `DEF_SECTOR;
            n.cyl     = 16'h0;
            n.head    = `DEF_DRVHEAD;
            n.err_reg = `DIAG_PASS;
        end
        n.irq_n = !(n.irq_pend && !n.irq_disable);
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            s <= '0;
            s.st      <= ata_tf_pkg::S_IDLE;
            s.count   <= `DEF_COUNT;
            s.sector  <= `DEF_SECTOR;
            s.head    <= `DEF_DRVHEAD;
            s.err_reg <= `DIAG_PASS;
            s.cfg     <= `DEF_CFG;
            s.drdy    <= 1'b1;
            s.dsc     <= 1'b1;
            s.irq_n   <= 1'b1;
        end
        else
            s <= n;
    end

    assign prdata              = s.prdata;
    assign pready              = s.pready;
    assign pslverr             = s.pslverr;
    assign media               = s.media;
    assign interrupt_request_n = s.irq_n;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    sequence cmd_issue;
        cmd_ok && decode(pwdata[7:0]) == ata_tf_pkg::OP_BAD;
    endsequence
    sequence abort_end;
        ##[1:40] (!s.busy && s.errb && s.err_reg[`ER_ABRT]);
    endsequence

    chk_task_file_reset_request_busy: assert property (s.task_file_reset_request |-> s.busy)
        else $error("busy low while soft reset held");
    chk_task_file_reset_request_hold: assert property (
        s.task_file_reset_request && !(wr && paddr == `OFF_ALTCTRL) |=> s.task_file_reset_request)
        else $error("soft reset released without host write");
    chk_cfg_keep: assert property (
        $rose(s.task_file_reset_request) |-> s.cfg == $past(s.cfg))
        else $error("soft reset changed card configuration");
    chk_irq_mask: assert property (
        s.irq_disable |-> interrupt_request_n)
        else $error("interrupt asserted while disabled");
    chk_drvaddr_inv: assert property (
        rd && paddr == `OFF_DRVADDR
        |-> prdata[5:2] == ~s.head[3:0])
        else $error("drive address not inverted head");
    chk_drvaddr_ro: assert property (
        wr && paddr == `OFF_DRVADDR && !s.task_file_reset_request
        |=> s.head == $past(s.head))
        else $error("drive address write changed state");
    chk_cmd_status: assert property (
        cmd_ok |=> s.busy && !s.errb && !s.dsc && !s.drdy)
        else $error("command write status wrong");
    chk_unsup_abort: assert property (
        cmd_issue |-> abort_end)
        else $error("unsupported command not aborted");
    chk_format_nowr: assert property (
        s.op == ata_tf_pkg::OP_FORMAT |-> !media.wr)
        else $error("format data written to media");
    chk_task_file_reset_request_release: assert property (
        $fell(s.task_file_reset_request) |-> ##[1:40] (!s.busy
        && s.count == `DEF_COUNT))
        else $error("soft reset release did not finish");
endmodule

// ===== verif/media_model.sv
// Stand-in for the media engine behind the task-file controller.
// Assumes one-cycle start, rd and wr pulses on core_clk.
`timescale 1ns/1ps
module media_model (
    input  wire logic               core_clk,
    input  wire logic               reset,
    input  wire ata_tf_pkg::media_s media,
    output logic [15:0]             media_rdata,
    output int                      n_start,
    output int                      n_rd,
    output int                      n_wr,
    output ata_tf_pkg::op_e         last_op,
    output logic [15:0]             last_wdata
);
    // The low byte moves on every word, but the bench checks only the high byte 8'ha5.
    assign media_rdata = {8'ha5, n_rd[7:0]};
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            n_start <= 0;
            n_rd <= 0;
            n_wr <= 0;
            last_op <= ata_tf_pkg::OP_BAD;
            last_wdata <= 16'h0000;
        end
        else
        begin
            n_start <= n_start + 32'(media.start);
            n_rd <= n_rd + 32'(media.rd);
            n_wr <= n_wr + 32'(media.wr);
            if (media.start)
                last_op <= media.op;
            if (media.wr)
                last_wdata <= media.wdata;
        end
    end
endmodule

// ===== verif/ata_task_file_command_control_tb.sv
// Self-checking bench for the task-file command controller.
// Assumes the media stand-in answers reads; APB master at 20 MHz.
`timescale 1ns/1ps
`include "ata_tf_cfg.svh"
module ata_task_file_command_control_tb;
    localparam int SW = 4;
    logic core_clk = 1'b0, reset = 1'b1, drive_is_one = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, err, interrupt_request_n;
    logic [15:0] media_rdata, last_wdata;
    ata_tf_pkg::media_s media;
    ata_tf_pkg::op_e last_op;
    int n_start, n_rd, n_wr, fails = 0, n_checks = 0;
    ata_task_file_command_control #(.SECTOR_WORDS(SW))
        ata_task_file_command_control_inst (
        .core_clk(core_clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .drive_is_one(drive_is_one),
        .media_rdata(media_rdata), .media(media),
        .interrupt_request_n(interrupt_request_n));
    media_model media_model_inst (
        .core_clk(core_clk), .reset(reset), .media(media),
        .media_rdata(media_rdata), .n_start(n_start), .n_rd(n_rd),
        .n_wr(n_wr), .last_op(last_op), .last_wdata(last_wdata));
    always #25 core_clk = ~core_clk;
    // ********
    // Helpers
    // ********
    task automatic chk(input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1 && ++n < 20);
        if (pready !== 1'b1)
        begin
            fails++;
            $display("MISMATCH %0t no pready", $time);
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    // Alternate status is polled so that a pending request survives.
    task automatic wait_st(input int b, input logic v);
        int n;
        n = 0;
        do apb(1'b0, `OFF_ALTCTRL, 32'h0); while (q[b] !== v && ++n < 60);
        chk(32'(q[b]), 32'(v));
    endtask
    task automatic cmd(input logic [7:0] c);
        apb(1'b1, `OFF_STATCMD, {24'h0, c});
        apb(1'b0, `OFF_ALTCTRL, 32'h0);
        chk(q & 32'hd1, 32'h80);
        wait_st(7, 1'b0);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ********
    // Scenarios
    // ********
    task automatic t_regs();
        logic [7:0] ad[6] = '{`OFF_STATCMD, `OFF_COUNT, `OFF_SECTOR,
                              `OFF_DRVHEAD, `OFF_ERRFEAT, `OFF_CARDCFG};
        logic [7:0] ex[6] = '{8'h50, 8'h01, 8'h01, 8'ha0, 8'h01, 8'h00};
        foreach (ad[i])
        begin
            apb(1'b0, ad[i], 32'h0);
            chk(q, {24'h0, ex[i]});
        end
        // Only this test maps the drive address word; bit 7 is unsafe.
        for (int h = 0; h < 4; h++)
        begin
            apb(1'b1, `OFF_DRVHEAD, 32'ha0 | h);
            apb(1'b1, `OFF_DRVADDR, 32'hff);
            chk(32'(err), 32'h0);
            apb(1'b0, `OFF_DRVADDR, 32'h0);
            chk(q, {26'h0, ~h[3:0], 2'b00});
        end
        apb(1'b0, 8'h2c, 32'h0);
        chk(32'(err), 32'h1);
        $display("test regs done");
    endtask
    task automatic t_power();
        logic [7:0] c[12] = '{8'he5, 8'he2, 8'h98, 8'h96, 8'he0,
                              8'h94, 8'he6, 8'h99, 8'h90, 8'hc0,
                              8'he3, 8'h97};
        ata_tf_pkg::op_e o[12] = '{ata_tf_pkg::OP_CHKPWR,
            ata_tf_pkg::OP_STBY, ata_tf_pkg::OP_CHKPWR, ata_tf_pkg::OP_STBY,
            ata_tf_pkg::OP_STBY, ata_tf_pkg::OP_STBY, ata_tf_pkg::OP_SLEEP,
            ata_tf_pkg::OP_SLEEP, ata_tf_pkg::OP_DIAG, ata_tf_pkg::OP_ERASE,
            ata_tf_pkg::OP_IDLE, ata_tf_pkg::OP_IDLE};
        int n;
        foreach (c[i])
        begin
            n = n_start;
            cmd(c[i]);
            chk(n_start - n, 1);
            chk(32'(last_op), 32'(o[i]));
            chk(32'(interrupt_request_n), 32'h0);
            apb(1'b0, `OFF_STATCMD, 32'h0);
            apb(1'b0, i == 8 ? `OFF_ERRFEAT : `OFF_COUNT, 32'h0);
            if (i == 0 || i == 2 || i == 8)
                chk(q, i == 0 ? 32'hff : 32'(i == 8));
            chk(32'(interrupt_request_n), 32'h1);
        end
        n = n_start;
        cmd(8'h55);
        chk(n_start - n, 0);
        chk(q & 32'h81, 32'h01);
        apb(1'b0, `OFF_ERRFEAT, 32'h0);
        chk(q, 32'h04);
        apb(1'b0, `OFF_STATCMD, 32'h0);
        $display("test power done");
    endtask
    task automatic t_xfer();
        logic [7:0] c[5] = '{8'h20, 8'hc4, 8'hec, 8'h30, 8'h50};
        int n;
        int m;
        apb(1'b1, `OFF_SECTOR, 32'h20);
        apb(1'b0, `OFF_SECTOR, 32'h0);
        chk(q, 32'h20);
        foreach (c[i])
        begin
            n = n_rd;
            m = n_wr;
            cmd(c[i]);
            wait_st(3, 1'b1);
            for (int k = 0; k < SW; k++)
            begin
                apb(i > 2, `OFF_DATA, 32'h1230 + k);
                if (i < 3)
                    chk(32'(q[15:8]), 32'ha5);
            end
            // The last word's pulse is counted one edge after its access.
            wait_st(3, 1'b0);
            chk(n_rd - n, i < 3 ? SW : 0);
            chk(n_wr - m, i == 3 ? SW : 0);
            apb(1'b0, `OFF_STATCMD, 32'h0);
        end
        chk(32'(last_op), 32'(ata_tf_pkg::OP_FORMAT));
        chk(32'(last_wdata), 32'h1230 + SW - 1);
        $display("test xfer done");
    endtask
    task automatic t_irq();
        int n;
        apb(1'b1, `OFF_ALTCTRL, 32'h0a);
        cmd(8'he1);
        chk(32'(interrupt_request_n), 32'h1);
        apb(1'b1, `OFF_ALTCTRL, 32'hf8);
        apb(1'b0, `OFF_ALTCTRL, 32'h0);
        chk(32'(interrupt_request_n), 32'h0);
        apb(1'b0, `OFF_STATCMD, 32'h0);
        apb(1'b0, `OFF_STATCMD, 32'h0);
        chk(32'(interrupt_request_n), 32'h1);
        apb(1'b1, `OFF_DRVHEAD, 32'hb0);
        n = n_start;
        apb(1'b1, `OFF_STATCMD, 32'he1);
        apb(1'b0, `OFF_ALTCTRL, 32'h0);
        chk(32'(q[7]), 32'h0);
        drive_is_one <= 1'b1;
        cmd(8'he1);
        chk(n_start - n, 1);
        $display("test irq done");
    endtask
    task automatic t_soft();
        apb(1'b1, `OFF_CARDCFG, 32'h3c);
        apb(1'b1, `OFF_COUNT, 32'h77);
        apb(1'b1, `OFF_ALTCTRL, 32'h0c);
        repeat (40) @(posedge core_clk);
        apb(1'b1, `OFF_COUNT, 32'h55);
        apb(1'b0, `OFF_ALTCTRL, 32'h0);
        chk(32'(q[7]), 32'h1);
        apb(1'b1, `OFF_ALTCTRL, 32'h08);
        wait_st(7, 1'b0);
        chk(q, 32'h50);
        apb(1'b0, `OFF_COUNT, 32'h0);
        chk(q, 32'h01);
        apb(1'b0, `OFF_DRVHEAD, 32'h0);
        chk(q, 32'ha0);
        apb(1'b0, `OFF_CARDCFG, 32'h0);
        chk(q, 32'h3c);
        $display("test soft reset done");
    endtask
    initial
    begin
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        t_regs();
        t_power();
        t_xfer();
        t_irq();
        t_soft();
        results();
    end
    // The whole sequence needs about a thousand cycles; this is ample.
    initial
    begin
        repeat (20000) @(posedge core_clk);
        fails++;
        results();
    end
endmodule
